// [fps_pkg.sv]
package fps_pkg;
    // Duty and level resolution
    localparam int LEVEL_W = 8;
    // PWM ramp width in bits, so a period is 256 clk_i cycles, one ramp step per cycle
    localparam int RAMP_W = 8;
    localparam logic [7:0] RAMP_MAX = 8'hff;
    // Sequencer interval lengths in PWM cycles
    localparam int CYC_W = 6;
    localparam logic [5:0] STARTUP_CYCLES = 6'h20;
    localparam logic [5:0] DIAG_CYCLES = 6'h03;
    localparam logic [5:0] MISS_CYCLES = 6'h20;
    // Control-range bounds as temperature-level codes
    localparam logic [7:0] CTRL_LO = 8'h40;
    localparam logic [7:0] CTRL_HI = 8'hc0;
    // Blanking window after drive turn-on, in clk_i cycles
    localparam logic [3:0] BLANK_CYCLES = 4'h4;
    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_THR = 8'h08;
    // Control field positions and reset values
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;
    localparam logic [7:0] AUTOOFF_THR_RESET = 8'h60;
    localparam logic [7:0] AUTOOFF_HYST_RESET = 8'h08;
    localparam logic [7:0] HALT_THR_RESET = 8'h10;
    localparam logic [7:0] RELEASE_THR_RESET = 8'h18;

    typedef enum logic [6:0] {
        ST_HALT = 7'h01,
        ST_OFF = 7'h02,
        ST_START1 = 7'h04,
        ST_START2 = 7'h08,
        ST_RUN = 7'h10,
        ST_DIAG = 7'h20,
        ST_RETRY = 7'h40
    } fps_state_t;
endpackage

// [fps_ramp.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_ramp #(
    parameter int W = fps_pkg::RAMP_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    output logic [W-1:0] ramp_o,
    output logic period_end_o
);
    // Period strobe marks the last ramp step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_o <= '0;
            period_end_o <= 1'b0;
        end else if (ce_i) begin
            ramp_o <= ramp_o + 1'b1;
            period_end_o <= (ramp_o == W'(fps_pkg::RAMP_MAX - 8'h01));
        end
    end
endmodule
`default_nettype wire

// [fps_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1;
    logic s2;
    logic s3;
    // Change accepted only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// [fps_seq.sv]
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fps_seq #(
    parameter int LW = fps_pkg::LEVEL_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [LW-1:0] temp_level_in_i,
    input wire logic fan_pulse_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic fan_drive_out_o,
    output logic fault_n_o
);
    localparam int CW = fps_pkg::CYC_W;

    logic [fps_pkg::RAMP_W-1:0] ramp;
    logic period_end;
    logic pulse_lvl;
    logic pulse_d;
    logic pulse_raw;
    logic pulse;
    logic [3:0] blank_cnt;
    logic drive_d;
    logic [LW-1:0] level;
    logic level_vld;
    logic [LW-1:0] duty;
    logic [LW-1:0] next_duty;
    logic [CW-1:0] seq_cnt;
    logic [CW-1:0] miss_cnt;
    logic pulse_seen;
    logic halted;
    logic autooff;
    logic fault;
    logic run_en;
    logic [7:0] autooff_threshold;
    logic [7:0] autooff_hysteresis;
    logic [7:0] halt_threshold;
    logic [7:0] release_threshold;
    logic halt_cmp;
    logic release_cmp;
    logic off_enter_cmp;
    logic off_exit_cmp;
    logic full_on;
    logic pwm_on;
    fps_pkg::fps_state_t state;

    fps_ramp u_ramp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ramp_o(ramp),
        .period_end_o(period_end)
    );

    fps_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(fan_pulse_i),
        .q_o(pulse_lvl)
    );

    // Linear duty map with clamping at both bounds
    function automatic logic [LW-1:0] map_duty(input logic [LW-1:0] lv);
        logic [LW+8:0] num;
        num = '0;
        if (lv <= LW'(fps_pkg::CTRL_LO)) begin
            map_duty = '0;
        end else if (lv >= LW'(fps_pkg::CTRL_HI)) begin
            map_duty = '1;
        end else begin
            num = (LW+9)'(lv - LW'(fps_pkg::CTRL_LO)) * (LW+9)'(255);
            map_duty = LW'(num / (LW+9)'(fps_pkg::CTRL_HI - fps_pkg::CTRL_LO));
        end
    endfunction

    // Level held one cycle so all comparisons see one sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level <= '0;
        end else if (ce_i) begin
            level <= temp_level_in_i;
        end
    end

    // Reset leaves level at zero, below halt; flags wait for a real sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_vld <= 1'b0;
        end else if (ce_i) begin
            level_vld <= 1'b1;
        end
    end

    // Threshold comparisons as flags
    always_comb begin
        halt_cmp = (level < LW'(halt_threshold));
        release_cmp = (level > LW'(release_threshold));
        off_enter_cmp = (level < LW'(autooff_threshold));
        off_exit_cmp = ({1'b0, level} > ({1'b0, autooff_threshold} + {1'b0, autooff_hysteresis}));
        next_duty = map_duty(level);
    end

    // Pulse edge detection and blanking after turn-on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_d <= 1'b0;
            drive_d <= 1'b0;
            blank_cnt <= '0;
        end else if (ce_i) begin
            pulse_d <= pulse_lvl;
            drive_d <= fan_drive_out_o;
            if (fan_drive_out_o && !drive_d) begin
                blank_cnt <= fps_pkg::BLANK_CYCLES;
            end else if (blank_cnt != '0) begin
                blank_cnt <= blank_cnt - 4'h1;
            end
        end
    end
    assign pulse_raw = pulse_lvl && !pulse_d;
    assign pulse = pulse_raw && (blank_cnt == '0);

    // Duty latched at each period boundary, so no mid-period glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty <= '0;
        end else if (ce_i && period_end) begin
            duty <= next_duty;
        end
    end

    // Halt and auto-off mode flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halted <= 1'b0;
            autooff <= 1'b0;
        end else if (ce_i && level_vld) begin
            if (halt_cmp || !run_en) begin
                halted <= 1'b1;
            end else if (release_cmp) begin
                halted <= 1'b0;
            end
            if (off_enter_cmp) begin
                autooff <= 1'b1;
            end else if (off_exit_cmp) begin
                autooff <= 1'b0;
            end
        end
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= fps_pkg::ST_START1;
            seq_cnt <= '0;
            miss_cnt <= '0;
            pulse_seen <= 1'b0;
            fault <= 1'b0;
        end else if (ce_i) begin
            if (halted) begin
                // Halt is a full reset, also of a latched fault
                state <= fps_pkg::ST_HALT;
                seq_cnt <= '0;
                miss_cnt <= '0;
                pulse_seen <= 1'b0;
                fault <= 1'b0;
            end else if (fault) begin
                state <= fps_pkg::ST_HALT;
            end else if (autooff || (state == fps_pkg::ST_HALT && !off_exit_cmp)) begin
                state <= fps_pkg::ST_OFF;
                seq_cnt <= '0;
                miss_cnt <= '0;
                pulse_seen <= 1'b0;
            end else begin
                case (state)
                    fps_pkg::ST_HALT, fps_pkg::ST_OFF: begin
                        state <= fps_pkg::ST_START1;
                        seq_cnt <= '0;
                    end
                    fps_pkg::ST_START1, fps_pkg::ST_START2, fps_pkg::ST_RETRY: begin
                        if (pulse) begin
                            state <= fps_pkg::ST_RUN;
                            miss_cnt <= '0;
                            seq_cnt <= '0;
                        end else if (period_end) begin
                            if (seq_cnt == fps_pkg::STARTUP_CYCLES - 6'h01) begin
                                seq_cnt <= '0;
                                if (state == fps_pkg::ST_START1) begin
                                    state <= fps_pkg::ST_START2;
                                end else begin
                                    fault <= 1'b1;
                                    state <= fps_pkg::ST_HALT;
                                end
                            end else begin
                                seq_cnt <= seq_cnt + 6'h01;
                            end
                        end
                    end
                    fps_pkg::ST_RUN: begin
                        // Pulse captured this period restarts the loop
                        if (pulse) begin
                            pulse_seen <= 1'b1;
                        end
                        if (period_end) begin
                            pulse_seen <= 1'b0;
                            if (pulse_seen || pulse) begin
                                miss_cnt <= '0;
                            end else if (miss_cnt == fps_pkg::MISS_CYCLES - 6'h01) begin
                                miss_cnt <= '0;
                                seq_cnt <= '0;
                                state <= fps_pkg::ST_DIAG;
                            end else begin
                                miss_cnt <= miss_cnt + 6'h01;
                            end
                        end
                    end
                    fps_pkg::ST_DIAG: begin
                        if (pulse) begin
                            state <= fps_pkg::ST_RUN;
                            miss_cnt <= '0;
                            seq_cnt <= '0;
                        end else if (period_end) begin
                            if (seq_cnt == fps_pkg::DIAG_CYCLES - 6'h01) begin
                                seq_cnt <= '0;
                                state <= fps_pkg::ST_RETRY;
                            end else begin
                                seq_cnt <= seq_cnt + 6'h01;
                            end
                        end
                    end
                    default: begin
                        state <= fps_pkg::ST_HALT;
                    end
                endcase
            end
        end
    end

    assign full_on = (state == fps_pkg::ST_START1) || (state == fps_pkg::ST_START2)
        || (state == fps_pkg::ST_DIAG) || (state == fps_pkg::ST_RETRY);
    assign pwm_on = (state == fps_pkg::ST_RUN) && (ramp < duty);

    // Outputs registered; drive off in halt, off and fault
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fan_drive_out_o <= 1'b0;
            fault_n_o <= 1'b1;
        end else if (ce_i) begin
            fan_drive_out_o <= (full_on || pwm_on) && !fault && !halted && !autooff;
            fault_n_o <= !(fault && !halted);
        end
    end

    // Wishbone control and threshold registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_en <= fps_pkg::CTRL_RESET[fps_pkg::CTRL_RUN_BIT];
            autooff_threshold <= fps_pkg::AUTOOFF_THR_RESET;
            autooff_hysteresis <= fps_pkg::AUTOOFF_HYST_RESET;
            halt_threshold <= fps_pkg::HALT_THR_RESET;
            release_threshold <= fps_pkg::RELEASE_THR_RESET;
        end else if (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
            if (wb_adr_i[7:0] == fps_pkg::REG_CTRL) begin
                if (wb_sel_i[0]) begin
                    run_en <= wb_dat_i[fps_pkg::CTRL_RUN_BIT];
                end
            end else if (wb_adr_i[7:0] == fps_pkg::REG_THR) begin
                if (wb_sel_i[0]) begin
                    autooff_threshold <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    autooff_hysteresis <= wb_dat_i[15:8];
                end
                if (wb_sel_i[2]) begin
                    halt_threshold <= wb_dat_i[23:16];
                end
                if (wb_sel_i[3]) begin
                    release_threshold <= wb_dat_i[31:24];
                end
            end
        end
    end

    // Ack one cycle after request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_adr_i[7:0] == fps_pkg::REG_CTRL) begin
                wb_dat_o <= {31'h0, run_en};
            end else if (wb_adr_i[7:0] == fps_pkg::REG_STAT) begin
                wb_dat_o <= {8'h0, duty, 6'h0, fault, autooff, halted, state};
            end else if (wb_adr_i[7:0] == fps_pkg::REG_THR) begin
                wb_dat_o <= {release_threshold, halt_threshold,
                    autooff_hysteresis, autooff_threshold};
            end else begin
                wb_dat_o <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// [fps_fan_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_fan_model (
    input wire logic clk_i,
    input wire logic spin_i,
    input wire logic drive_i,
    output logic pulse_o
);
    logic [5:0] dcnt = 6'h0;
    // Rotor only advances while energized, so low duty gives few edges
    always_ff @(posedge clk_i) begin
        if (drive_i && spin_i) begin
            dcnt <= dcnt + 6'h1;
        end
    end
    // A stalled rotor gives no commutation edges at all
    assign pulse_o = spin_i && (dcnt[5:3] == 3'h5);
endmodule
`default_nettype wire

// [fps_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_seq_assertions #(
    parameter int LW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [LW-1:0] temp_level_in_i,
    input wire logic fan_drive_out_o,
    input wire logic fault_n_o
);
    logic [15:0] since_rst = 16'h0;
    logic [9:0] lo_age = 10'h0;
    logic [9:0] hi_age = 10'h0;
    logic [9:0] off_age = 10'h0;
    logic [9:0] on_age = 10'h0;
    logic faulted = 1'h0;
    // Saturating age counters; thresholds assume the default halt and auto-off codes
    function automatic logic [9:0] step(input logic c, input logic [9:0] v);
        return !c ? 10'h0 : ((v == 10'h3ff) ? v : v + 10'h1);
    endfunction
    always_ff @(posedge clk_i) begin
        lo_age <= step(temp_level_in_i < 8'h10, lo_age);
        hi_age <= step(temp_level_in_i >= 8'h10, hi_age);
        off_age <= step(temp_level_in_i < 8'h60, off_age);
        on_age <= step(fan_drive_out_o, on_age);
    end
    always_ff @(posedge clk_i) begin
        since_rst <= rst_i ? 16'h0 : ((since_rst == 16'hffff) ? since_rst : since_rst + 16'h1);
        faulted <= rst_i ? 1'h0 : (faulted || !fault_n_o);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_STARTUP_ON: assert property (since_rst inside {[16'h8:16'h1f40]} |-> fan_drive_out_o)
        else $error("drive dropped during power-up start-up");
    AST_FIRST_FAULT: assert property ($fell(fault_n_o) && !faulted |->
        since_rst inside {[16'h3fac:16'h413c]}) else $error("first fault at wrong time");
    AST_FAULT_DRIVE: assert property (!fault_n_o && $past(!fault_n_o) |-> !fan_drive_out_o)
        else $error("drive active while faulted");
    AST_FAULT_HOLD: assert property (!fault_n_o && hi_age > 10'h12c |=> !fault_n_o)
        else $error("fault released without halt");
    AST_RELEASE: assert property ($rose(fault_n_o) |-> hi_age < 10'h258)
        else $error("fault cleared with no recent halt level");
    AST_HALT_QUIET: assert property (lo_age == 10'h12c |-> fault_n_o && !fan_drive_out_o)
        else $error("halt did not clear fault and drive");
    AST_OFF_QUIET: assert property (off_age == 10'h12c |-> fault_n_o && !fan_drive_out_o)
        else $error("auto-off did not quiet outputs");
    AST_GIVE_UP: assert property ($fell(fault_n_o) |-> $past(on_age, 2) > 10'h3e8)
        else $error("fault without a full-on start-up before it");
    cover property ($fell(fault_n_o));
    cover property ($rose(fault_n_o));
    cover property (off_age == 10'h12c && lo_age == 10'h0);
endmodule
bind fps_seq fps_seq_assertions #(.LW(LW)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .temp_level_in_i(temp_level_in_i), .fan_drive_out_o(fan_drive_out_o), .fault_n_o(fault_n_o));
`default_nettype wire

// [fan_pwm_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module fan_pwm_sequencer_tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce_i = 1'h1;
    logic spin = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] lvl = 8'hc0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] rd;
    logic [31:0] d;
    wire logic [31:0] rdat;
    wire logic ack;
    wire logic drive;
    wire logic fault_n;
    wire logic pulse;
    int errors = 0;
    int compares = 0;
    int cyc_n = 0;
    int t0;
    int e;
    int nh;
    int lv[$] = '{192, 160, 128};
    always #2.5 clk_i = ~clk_i;
    fps_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .temp_level_in_i(lvl),
        .fan_pulse_i(pulse), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fan_drive_out_o(drive), .fault_n_o(fault_n));
    fps_fan_model fan_u (.clk_i(clk_i), .spin_i(spin), .drive_i(drive), .pulse_o(pulse));
    // Duty law: control range onto 0..255, clamped at both ends
    function automatic int exp_duty(input int l);
        if (l <= 64) return 0;
        if (l >= 192) return 255;
        return (l - 64) * 255 / 128;
    endfunction
    task automatic wrap_up();
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dd,
                      input logic [3:0] s);
        int n;
        n = 0;
        adr <= {24'h0, a};
        we <= w;
        wdat <= dd;
        sel <= s;
        cyc <= 1'h1;
        stb <= 1'h1;
        @(posedge clk_i);
        while (ack !== 1'h1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) errors++;
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk_i);
    endtask
    // Status polling costs three cycles a read, so limits are in reads
    task automatic poll(input logic [31:0] m, input logic [31:0] v, input int lim);
        int n;
        n = 0;
        wb(8'h04, 1'h0, 32'h0, 4'hf);
        while ((rd & m) !== v && n < lim) begin
            wb(8'h04, 1'h0, 32'h0, 4'hf);
            n++;
        end
        `CHK("status", v, rd & m)
    endtask
    task automatic ontime(input int ex);
        nh = 0;
        repeat (256) begin
            @(posedge clk_i);
            if (drive === 1'h1) nh++;
        end
        `CHK("on-time", 1'h1, nh inside {[ex - 3:ex + 3]})
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 90000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(65));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        t0 = cyc_n;
        wb(8'h00, 1'h0, 32'h0, 4'hf);
        `CHK("ctrl", fps_pkg::CTRL_RESET, rd)
        wb(8'h0c, 1'h1, $urandom, 4'hf);
        wb(8'h0c, 1'h0, 32'h0, 4'hf);
        `CHK("unmapped", 32'h0, rd)
        d = $urandom;
        wb(8'h08, 1'h1, d, 4'h2);
        wb(8'h08, 1'h0, 32'h0, 4'hf);
        d = {fps_pkg::RELEASE_THR_RESET, fps_pkg::HALT_THR_RESET, d[15:8], 8'h60};
        `CHK("thr", d, rd)
        wb(8'h08, 1'h1, 32'h18100874, 4'hf);
        poll(32'h7f, 32'(fps_pkg::ST_START1), 0);
        `CHK("drive", 1'h1, drive)
        poll(32'h7f, 32'(fps_pkg::ST_START2), 4000);
        `CHK("start2 time", 1'h1, (cyc_n - t0) inside {[8192:8700]})
        poll(32'h200, 32'h200, 4000);
        `CHK("fault", 1'h0, fault_n)
        spin <= 1'h1;
        repeat (1024) @(posedge clk_i);
        `CHK("fault", 1'h0, fault_n)
        `CHK("drive", 1'h0, drive)
        lvl <= 8'h08;
        repeat (600) @(posedge clk_i);
        poll(32'h7f, 32'(fps_pkg::ST_HALT), 0);
        `CHK("fault", 1'h1, fault_n)
        lvl <= 8'hc0;
        poll(32'h7f, 32'(fps_pkg::ST_RUN), 400);
        foreach (lv[i]) begin
            lvl <= 8'(lv[i]);
            repeat (600) @(posedge clk_i);
            e = exp_duty(lv[i]);
            wb(8'h04, 1'h0, 32'h0, 4'hf);
            `CHK("duty", 1'h1, rd[23:16] inside {[e - 2:e + 2]})
            ontime(e);
        end
        poll(32'h7f, 32'(fps_pkg::ST_RUN), 0);
        lvl <= 8'h50;
        repeat (600) @(posedge clk_i);
        poll(32'h7f, 32'(fps_pkg::ST_OFF), 0);
        lvl <= 8'h78;
        repeat (600) @(posedge clk_i);
        poll(32'h7f, 32'(fps_pkg::ST_OFF), 0);
        // Enable low must hold off-state even though the level now asks to restart
        ce_i <= 1'h0;
        spin <= 1'h0;
        lvl <= 8'h90;
        repeat (600) @(posedge clk_i);
        `CHK("frozen drive", 1'h0, drive)
        ce_i <= 1'h1;
        poll(32'h7f, 32'(fps_pkg::ST_START1), 400);
        spin <= 1'h1;
        poll(32'h7f, 32'(fps_pkg::ST_RUN), 4000);
        spin <= 1'h0;
        t0 = cyc_n;
        poll(32'h7f, 32'(fps_pkg::ST_DIAG), 4000);
        `CHK("miss time", 1'h1, (cyc_n - t0) inside {[7936:8960]})
        `CHK("drive", 1'h1, drive)
        spin <= 1'h1;
        poll(32'h7f, 32'(fps_pkg::ST_RUN), 400);
        spin <= 1'h0;
        poll(32'h7f, 32'(fps_pkg::ST_DIAG), 4000);
        poll(32'h7f, 32'(fps_pkg::ST_RETRY), 400);
        `CHK("drive", 1'h1, drive)
        poll(32'h200, 32'h200, 4000);
        `CHK("fault", 1'h0, fault_n)
        wrap_up();
    end
endmodule
`default_nettype wire
